//--- hw/bpm_pkg.sv
package bpm_pkg;
  // iteration counts and the tail that may not be broken into
  localparam logic [4:0] ITER_WORD = 5'h10;
  localparam logic [4:0] ITER_HALF = 5'h08;
  localparam logic [4:0] IO_TAIL = 5'h04;
  localparam int IMM_MSB = 19;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPERAND = 8'h04;
  localparam logic [7:0] OFS_REG_R = 8'h08;
  localparam logic [7:0] OFS_REG_R1 = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RES_R = 8'h14;
  localparam logic [7:0] OFS_RES_R1 = 8'h18;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OP_IMM = 2'b00,
    OP_WORD = 2'b01,
    OP_HALF = 2'b10
  } bpm_op_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_XFER = 3'b001,
    S_ITER = 3'b010,
    S_IOWAIT = 3'b011,
    S_SIGN = 3'b100,
    S_STORE = 3'b101
  } bpm_state_e;

  typedef struct packed {
    logic negative;
    logic positive;
    logic unrep;
  } bpm_cc_s;

  typedef struct packed {
    logic [22:0] rsvd0;
    logic start;
    logic [3:0] rsvd1;
    logic low_half;
    logic odd_field;
    logic [1:0] op;
  } bpm_ctrl_s;

  typedef struct packed {
    logic [13:0] rsvd0;
    logic wrote_r1;
    logic wrote_r;
    logic [2:0] rsvd1;
    logic [4:0] count;
    logic [1:0] rsvd2;
    logic io_paused;
    bpm_cc_s cc;
    logic done;
    logic busy;
  } bpm_status_s;
endpackage

//--- hw/bpm_sequencer.sv
module bpm_sequencer (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic io_request,
  input wire logic io_return_strobe,
  output logic io_service_enable
);
  logic [1:0] rst_sync, pr;
  logic [7:0] aw_addr_q, waddr;
  logic [3:0] w_strb_q;
  logic [4:0] counter;
  logic [31:0] w_data_q, wmask, operand, reg_r, reg_r1, res_r, res_r1, mcand, mplier_src, a, b, c, rd_word;
  logic [32:0] d, next_d, top33;
  logic [33:0] a_ext, sum;
  logic rst_n, wr_en, start_go, half_new, rd_hit, wr_hit, single, sub, pass, io_take, step, is_half;
  logic pair_carry, save_ext_hi, save_ext_lo, sign_ext, done, wrote_r, wrote_r1;
  bpm_pkg::bpm_ctrl_s ctrl, ctrl_new;
  bpm_pkg::bpm_state_e state;
  bpm_pkg::bpm_cc_s cc;
  bpm_pkg::bpm_status_s status;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];
  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave, one write and one read in flight
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b1;
      w_data_q <= bpm_pkg::RESET_WORD;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end
  assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign waddr = {aw_addr_q[7:2], 2'b00};
  // read-only registers accept writes silently; only holes answer slverr
  assign wr_hit = waddr <= bpm_pkg::OFS_RES_R1;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bpm_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? bpm_pkg::RESP_OKAY : bpm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wmask[8*i+:8] = {8{w_strb_q[i]}};
  end
  assign ctrl_new = (ctrl & ~wmask) | (w_data_q & wmask);
  assign half_new = ctrl_new.op == bpm_pkg::OP_HALF;
  assign start_go = wr_en && waddr == bpm_pkg::OFS_CTRL && ctrl_new.start && state == bpm_pkg::S_IDLE;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= bpm_pkg::RESET_WORD;
      operand <= bpm_pkg::RESET_WORD;
      reg_r <= bpm_pkg::RESET_WORD;
      reg_r1 <= bpm_pkg::RESET_WORD;
    end else if (wr_en) begin
      unique case (waddr)
        bpm_pkg::OFS_CTRL: begin
          ctrl.op <= ctrl_new.op;
          ctrl.odd_field <= ctrl_new.odd_field;
          ctrl.low_half <= ctrl_new.low_half;
        end
        bpm_pkg::OFS_OPERAND: operand <= (operand & ~wmask) | (w_data_q & wmask);
        bpm_pkg::OFS_REG_R: reg_r <= (reg_r & ~wmask) | (w_data_q & wmask);
        bpm_pkg::OFS_REG_R1: reg_r1 <= (reg_r1 & ~wmask) | (w_data_q & wmask);
        default: ;
      endcase
    end
  end
  assign status = '{rsvd0: 14'h0000, wrote_r1: wrote_r1, wrote_r: wrote_r, rsvd1: 3'h0,
                    count: counter, rsvd2: 2'h0, io_paused: state == bpm_pkg::S_IOWAIT,
                    cc: cc, done: done, busy: state != bpm_pkg::S_IDLE};
  always_comb begin
    rd_word = bpm_pkg::RESET_WORD;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      bpm_pkg::OFS_CTRL: rd_word = {28'h0000000, ctrl[3:0]};
      bpm_pkg::OFS_OPERAND: rd_word = operand;
      bpm_pkg::OFS_REG_R: rd_word = reg_r;
      bpm_pkg::OFS_REG_R1: rd_word = reg_r1;
      bpm_pkg::OFS_STATUS: rd_word = status;
      bpm_pkg::OFS_RES_R: rd_word = res_r;
      bpm_pkg::OFS_RES_R1: rd_word = res_r1;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= bpm_pkg::RESET_WORD;
      s_axi_rresp <= bpm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? bpm_pkg::RESP_OKAY : bpm_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand selection at start
  always_comb begin
    mcand = operand;
    case (bpm_pkg::bpm_op_e'(ctrl_new.op))
      bpm_pkg::OP_IMM: mcand = {{12{operand[bpm_pkg::IMM_MSB]}}, operand[bpm_pkg::IMM_MSB:0]};
      // halfword multiplicand sits in the upper half so the product lands in a
      bpm_pkg::OP_HALF: mcand = {(ctrl_new.low_half ? operand[15:0] : operand[31:16]), 16'h0000};
      default: mcand = operand;
    endcase
  end
  assign mplier_src = ctrl_new.odd_field ? reg_r : reg_r1;
  assign is_half = ctrl.op == bpm_pkg::OP_HALF;
  ////////////////////////////////////////////////////////////////////////////
  // bit-pair adder
  always_comb begin
    pr = (state == bpm_pkg::S_SIGN) ? {sign_ext, sign_ext} : b[1:0];
    single = pr[0] ^ pair_carry;
    next_d = single ? {c[31], c} : {c, 1'b0};
    sub = pr[1] & single;
    pass = (pr == 2'b00 && !pair_carry) || (pr == 2'b11 && pair_carry);
    a_ext = {{2{a[31]}}, a};
    if (pass) begin
      sum = a_ext;
    end else if (sub) begin
      sum = a_ext - {next_d[32], next_d};
    end else begin
      sum = a_ext + {next_d[32], next_d};
    end
  end
  assign io_take = state == bpm_pkg::S_ITER && io_request && io_service_enable;
  // the low-word half of an iteration; deferred to the return cycle on a break
  assign step = (state == bpm_pkg::S_ITER && !io_take) || (state == bpm_pkg::S_IOWAIT && io_return_strobe);

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= bpm_pkg::S_IDLE;
      counter <= 5'h00;
    end else begin
      unique case (state)
        bpm_pkg::S_IDLE: begin
          if (start_go) begin
            state <= bpm_pkg::S_XFER;
            counter <= half_new ? bpm_pkg::ITER_HALF : bpm_pkg::ITER_WORD;
          end
        end
        bpm_pkg::S_XFER: state <= bpm_pkg::S_ITER;
        bpm_pkg::S_ITER, bpm_pkg::S_IOWAIT: begin
          if (io_take) begin
            state <= bpm_pkg::S_IOWAIT;
          end else if (step) begin
            counter <= counter - 5'h01;
            state <= (counter == 5'h01) ? bpm_pkg::S_SIGN : bpm_pkg::S_ITER;
          end
        end
        bpm_pkg::S_SIGN: state <= bpm_pkg::S_STORE;
        bpm_pkg::S_STORE: state <= bpm_pkg::S_IDLE;
        default: state <= bpm_pkg::S_IDLE;
      endcase
    end
  end
  // window closes ahead of the last four iterations
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_service_enable <= 1'b0;
    end else begin
      io_service_enable <= state == bpm_pkg::S_XFER || (step && (counter - 5'h01) > bpm_pkg::IO_TAIL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // partial product and addend registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      a <= bpm_pkg::RESET_WORD;
      b <= bpm_pkg::RESET_WORD;
      c <= bpm_pkg::RESET_WORD;
      d <= 33'h000000000;
    end else begin
      if (start_go) begin
        c <= mcand;
        d <= {mcand[31], mcand};
        a <= half_new ? {16'h0000, mplier_src[15:0]} : mplier_src;
      end
      unique case (state)
        bpm_pkg::S_XFER: begin
          b <= a;
          a <= bpm_pkg::RESET_WORD;
        end
        bpm_pkg::S_ITER: begin
          a <= sum[33:2];
          d <= next_d;
          if (!io_take) begin
            b <= {sum[1:0], b[31:2]};
          end
        end
        bpm_pkg::S_IOWAIT: begin
          if (io_return_strobe) begin
            b <= {save_ext_hi, save_ext_lo, b[31:2]};
          end
        end
        // sign correction lands at a's weight, so no shift here
        bpm_pkg::S_SIGN: begin
          a <= sum[31:0];
          d <= next_d;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pair_carry <= 1'b0;
      save_ext_hi <= 1'b0;
      save_ext_lo <= 1'b0;
      sign_ext <= 1'b0;
    end else begin
      if (state == bpm_pkg::S_XFER) begin
        pair_carry <= 1'b0;
        save_ext_hi <= 1'b0;
        save_ext_lo <= 1'b0;
        sign_ext <= 1'b0;
      end
      if (step) begin
        if (sub || (pr == 2'b11 && pair_carry)) begin
          pair_carry <= 1'b1;
        end else if (!pr[1]) begin
          pair_carry <= 1'b0;
        end
      end
      if (state == bpm_pkg::S_ITER) begin
        save_ext_hi <= sum[1];
        save_ext_lo <= sum[0];
      end
      if (state == bpm_pkg::S_ITER && !io_take && counter == 5'h01) begin
        sign_ext <= b[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // condition flags and result registers
  assign top33 = {a, b[31]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cc <= '0;
      done <= 1'b0;
      wrote_r <= 1'b0;
      wrote_r1 <= 1'b0;
      res_r <= bpm_pkg::RESET_WORD;
      res_r1 <= bpm_pkg::RESET_WORD;
    end else if (start_go) begin
      cc <= '0;
      done <= 1'b0;
      wrote_r <= 1'b0;
      wrote_r1 <= 1'b0;
    end else if (state == bpm_pkg::S_STORE) begin
      done <= 1'b1;
      cc.negative <= a[31];
      cc.positive <= !a[31] && (|a || (!is_half && |b));
      cc.unrep <= !is_half && !(&top33 || !(|top33));
      if (is_half) begin
        if (ctrl.odd_field) begin
          res_r <= a;
          wrote_r <= 1'b1;
        end else begin
          res_r1 <= a;
          wrote_r1 <= 1'b1;
        end
      end else if (ctrl.odd_field) begin
        res_r <= b;
        wrote_r <= 1'b1;
      end else begin
        res_r <= a;
        res_r1 <= b;
        wrote_r <= 1'b1;
        wrote_r1 <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_last_iter;
    state == bpm_pkg::S_ITER && counter == 5'h01 && !io_take;
  endsequence
  sequence s_finish;
    state == bpm_pkg::S_SIGN ##1 state == bpm_pkg::S_STORE ##1 state == bpm_pkg::S_IDLE;
  endsequence
  property p_finish;
    s_last_iter |=> s_finish;
  endproperty
  a_count_load: assert property (start_go |=> state == bpm_pkg::S_XFER && !cc.unrep
    && counter == ($past(half_new) ? 5'h08 : 5'h10)) else $error("bad iteration count at start");
  a_count_step: assert property (step |=> counter == $past(counter) - 5'h01)
    else $error("counter did not step down");
  a_sign_finish: assert property (p_finish) else $error("sign step not taken after last iteration");
  a_sign_subtract: assert property (state == bpm_pkg::S_SIGN && sign_ext && !pair_carry
    |=> a == $past(a) - $past(c)) else $error("sign step did not subtract");
  a_pass_high: assert property (state == bpm_pkg::S_ITER && pass
    |=> a == {{2{$past(a[31])}}, $past(a[31:2])}) else $error("pass pair changed high word");
  a_addend_pick: assert property (state == bpm_pkg::S_ITER && (b[0] ^ pair_carry)
    |=> d == {$past(c[31]), $past(c)}) else $error("addend not single multiplicand");
  a_carry_set: assert property (state == bpm_pkg::S_ITER && !io_take && b[1] && (b[0] ^ pair_carry)
    |=> pair_carry) else $error("pair carry not set");
  a_low_shift: assert property (state == bpm_pkg::S_ITER && !io_take
    |=> b[29:0] == $past(b[31:2])) else $error("low word not shifted");
  a_io_window: assert property (io_service_enable |-> state == bpm_pkg::S_ITER && counter > 5'h04)
    else $error("io window open in last four");
  a_io_hold: assert property (io_take |=> state == bpm_pkg::S_IOWAIT && b == $past(b))
    else $error("low word moved on io break");
  a_io_restore: assert property (state == bpm_pkg::S_IOWAIT && io_return_strobe
    |=> b[31:30] == {$past(save_ext_hi), $past(save_ext_lo)}) else $error("saved bits not restored");
  a_unrep_flag: assert property (state == bpm_pkg::S_STORE && !is_half
    |=> cc.unrep == !(&$past(top33) || !(|$past(top33)))) else $error("unrepresentable flag wrong");
endmodule // bpm_sequencer

//--- test/bpm_io_model.sv
module bpm_io_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic arm,
  input wire logic [3:0] delay,
  input wire logic io_service_enable,
  output logic io_request,
  output logic io_return_strobe,
  output int en_cycles,
  output int breaks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pending;
  logic [3:0] wait_cnt;
  // ask only while a break is offered, so the protected tail is never hit
  assign io_request = arm & ~pending & io_service_enable;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pending <= 1'b0;
      wait_cnt <= 4'h0;
      io_return_strobe <= 1'b0;
      en_cycles <= 0;
      breaks <= 0;
    end else begin
      io_return_strobe <= 1'b0;
      if (io_service_enable) begin
        en_cycles <= en_cycles + 1;
      end
      if (io_request) begin
        pending <= 1'b1;
        wait_cnt <= delay;
        breaks <= breaks + 1;
      end else if (pending) begin
        if (wait_cnt == 4'h0) begin
          pending <= 1'b0;
          io_return_strobe <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt - 4'h1;
        end
      end
    end
  end
endmodule // bpm_io_model

//--- test/bpm_sequencer_tb.sv
module bpm_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, io_req, io_ret, io_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic arm = 1'b0;
  logic [3:0] io_delay = 4'h0;
  int en_cycles, breaks;
  int err_total = 0;
  int comparisons = 0;
  // pairs chosen to hit every weight, carries, sign corners and overflow
  logic [31:0] mcands [8] = '{32'h3, 32'hfffffff9, 32'h7fffffff, 32'h80000000,
                              32'h12345678, 32'hffffffff, 32'h0, 32'h0001ffff};
  logic [31:0] mpliers [8] = '{32'h5, 32'hb, 32'h7fffffff, 32'h80000000,
                               32'haaaaaaaa, 32'hffffffff, 32'h5a5a5a5a, 32'h9c6dcf37};

  always #5 sys_clk = ~sys_clk;

  bpm_sequencer u_bpm_sequencer (
    .sys_clk(sys_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .io_request(io_req), .io_return_strobe(io_ret), .io_service_enable(io_en)
  );

  bpm_io_model u_bpm_io_model (
    .sys_clk(sys_clk), .resetn(resetn), .arm(arm), .delay(io_delay),
    .io_service_enable(io_en), .io_request(io_req), .io_return_strobe(io_ret),
    .en_cycles(en_cycles), .breaks(breaks)
  );

  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang(input string what);
    err_total++;
    $display("ERROR %s expected answer seen timeout", what);
    give_verdict();
  endtask

  ////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    logic aw_done, w_done;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 200);
    if (n >= 200) hang("write");
    // bready stays up: back-to-back calls would otherwise drop and raise it in one step
    resp = bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic ar_done;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_done = 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (!ar_done && arready) begin
        ar_done = 1'b1;
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1 && n < 200);
    if (n >= 200) hang("read");
    d = rdata;
    resp = rresp;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic mul(input bpm_pkg::bpm_op_e op, input logic odd, input logic lowh,
                     input logic [31:0] opnd, input logic [31:0] rr, input logic [31:0] rr1);
    logic [1:0] rs;
    logic [31:0] w, mc, mp, r0, r1;
    logic signed [63:0] p;
    logic unrep;
    bpm_pkg::bpm_ctrl_s c;
    bpm_pkg::bpm_status_s st;
    int n;
    axi_wr(bpm_pkg::OFS_OPERAND, opnd, rs);
    axi_wr(bpm_pkg::OFS_REG_R, rr, rs);
    axi_wr(bpm_pkg::OFS_REG_R1, rr1, rs);
    c = '0;
    c.op = op;
    c.odd_field = odd;
    c.low_half = lowh;
    c.start = 1'b1;
    axi_wr(bpm_pkg::OFS_CTRL, c, rs);
    n = 0;
    do begin
      axi_rd(bpm_pkg::OFS_STATUS, w, rs);
      st = w;
      n++;
    end while (st.done !== 1'b1 && n < 100);
    if (n >= 100) hang("done");
    mp = odd ? rr : rr1;
    if (op == bpm_pkg::OP_IMM) begin
      mc = {{12{opnd[19]}}, opnd[19:0]};
    end else if (op == bpm_pkg::OP_HALF) begin
      mc = lowh ? {{16{opnd[15]}}, opnd[15:0]} : {{16{opnd[31]}}, opnd[31:16]};
      mp = {{16{mp[15]}}, mp[15:0]};
    end else begin
      mc = opnd;
    end
    p = $signed(mc) * $signed(mp);
    unrep = (p !== {{32{p[31]}}, p[31:0]});
    axi_rd(bpm_pkg::OFS_RES_R, r0, rs);
    axi_rd(bpm_pkg::OFS_RES_R1, r1, rs);
    if (op == bpm_pkg::OP_HALF) begin
      check("half product", odd ? r0 : r1, p[31:0]);
    end else if (odd) begin
      check("low word in r", r0, p[31:0]);
    end else begin
      check("high word", r0, p[63:32]);
      check("low word", r1, p[31:0]);
    end
    check("flags", 32'(st.cc), 32'({p[63], (p != 64'sh0) && !p[63], unrep}));
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d, s0;
    logic [1:0] rs;
    int e0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    axi_rd(bpm_pkg::OFS_STATUS, d, rs);
    check("status after reset", d, bpm_pkg::RESET_WORD);
    axi_wr(8'h1c, 32'h5, rs);
    check("hole write resp", 32'(rs), 32'(bpm_pkg::RESP_SLVERR));
    axi_rd(8'h1c, d, rs);
    check("hole read data", d, 32'h0);
    check("hole read resp", 32'(rs), 32'(bpm_pkg::RESP_SLVERR));
    axi_wr(bpm_pkg::OFS_OPERAND, 32'h11223344, rs);
    wstrb <= 4'h6;
    axi_wr(bpm_pkg::OFS_OPERAND, 32'haabbccdd, rs);
    wstrb <= 4'hf;
    axi_rd(bpm_pkg::OFS_OPERAND, d, rs);
    check("byte strobes", d, 32'h11bbcc44);
    for (int i = 0; i < 8; i++) begin
      mul(bpm_pkg::OP_WORD, 1'b0, 1'b0, mcands[i], 32'h0, mpliers[i]);
    end
    for (int i = 1; i < 5; i++) begin
      mul(bpm_pkg::OP_WORD, 1'b1, 1'b0, mcands[i], mpliers[i], 32'h0);
    end
    // upper operand bits are junk on purpose: only the low twenty count
    mul(bpm_pkg::OP_IMM, 1'b0, 1'b0, 32'habc80003, 32'h0, 32'hfffffff9);
    mul(bpm_pkg::OP_IMM, 1'b1, 1'b0, 32'h1237ffff, 32'h80000003, 32'h0);
    mul(bpm_pkg::OP_HALF, 1'b0, 1'b0, 32'h80017fff, 32'h0, 32'h1234fffe);
    mul(bpm_pkg::OP_HALF, 1'b1, 1'b1, 32'h80017fff, 32'habcd8000, 32'h0);
    e0 = en_cycles;
    mul(bpm_pkg::OP_WORD, 1'b0, 1'b0, 32'h9abcdef1, 32'h0, 32'hb6db6db7);
    check("break window word", 32'(en_cycles - e0), 32'(bpm_pkg::ITER_WORD - bpm_pkg::IO_TAIL));
    e0 = en_cycles;
    mul(bpm_pkg::OP_HALF, 1'b0, 1'b1, 32'h0000c001, 32'h0, 32'h00007ffd);
    check("break window half", 32'(en_cycles - e0), 32'(bpm_pkg::ITER_HALF - bpm_pkg::IO_TAIL));
    // slow return, then prompt return, breaking every allowed iteration
    arm <= 1'b1;
    io_delay <= 4'h5;
    e0 = breaks;
    mul(bpm_pkg::OP_WORD, 1'b0, 1'b0, 32'h9abcdef1, 32'h0, 32'hb6db6db7);
    check("breaks word", 32'(breaks - e0), 32'(bpm_pkg::ITER_WORD - bpm_pkg::IO_TAIL));
    io_delay <= 4'h0;
    e0 = breaks;
    mul(bpm_pkg::OP_HALF, 1'b1, 1'b0, 32'h8765c001, 32'hffff7ffd, 32'h0);
    check("breaks half", 32'(breaks - e0), 32'(bpm_pkg::ITER_HALF - bpm_pkg::IO_TAIL));
    arm <= 1'b0;
    axi_rd(bpm_pkg::OFS_STATUS, s0, rs);
    axi_wr(bpm_pkg::OFS_STATUS, 32'hffffffff, rs);
    check("read-only write resp", 32'(rs), 32'(bpm_pkg::RESP_OKAY));
    axi_rd(bpm_pkg::OFS_STATUS, d, rs);
    check("status unchanged", d, s0);
    give_verdict();
  end
endmodule // bpm_sequencer_tb
